/* File: ttc_top.sv */
// Transmit tuning control register and transmit start logic
`include "ttc_regs.svh"

// Notes on behaviour
// - The programmed threshold applies only until the first transmit FIFO underrun.
// - Threshold field codes 00,01,10,11 select about 2K, 1.7K, 1K and 512 bytes.
// - A retried packet always uses the 2K threshold, i.e. store-and-forward.
// - Below 2K, transmit starts at the threshold count or at packet end, whichever first.
// - An underrun errors the packet and the retransmission waits for the whole packet.
// - At 2K nothing is sent until the end-of-packet token is stored.
// - When the retry limit register is zero, transmission is always store-and-forward.
// - The MPEG stamp enable turns on stamping for FMT 20h streams and resets to 0.
// - The DV stamp enable turns on stamping for FMT 00h streams and resets to 0.
// - The priority enable makes the link answer with priority arbitration, reset 0.
// - The acceleration enable tells the PHY the link supports acceleration, reset 0.
// - Reserved bit positions read as zero.
// - The marked enable bits are cleared only by the global reset.
// - Writing ones at the set address sets bits, at the clear address clears them.
module ttc_top
    import ttc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        global_reset_n,
    input  wire ttc_wr_s     reg_wr,
    output logic [31:0]      reg_rdata,
    input  wire ttc_fifo_s   fifo,
    input  wire logic        retry_limit_zero,
    input  wire logic [5:0]  stream_fmt,
    output logic             tx_start,
    output logic             stamp_apply,
    output logic             prio_arb_en,
    output logic             accel_notify,
    output logic             pipeline_dis
);

    logic [31:0] ctl_r;
    logic [31:0] ctl_nxt;
    logic [31:0] global_reset_n_r;
    logic [1:0]  thresh_r;
    logic        set_hit;
    logic        clr_hit;
    logic        pkt_clear;
    logic        underrun_seen_r;
    logic        sf_pkt_r;
    logic [11:0] byte_cnt_r;
    logic        eop_r;
    logic        started_r;
    logic        cnt_full;
    logic        cnt_reached;
    logic        start_req;
    logic        force_saf;
    logic        mpeg_hit;
    logic        dv_hit;
    logic [11:0] level;
    ttc_thresh_e th_sel;

    // Alias decode
    assign set_hit = reg_wr.wr && (reg_wr.addr == `TTC_SET_OFFSET);
    assign clr_hit = reg_wr.wr && (reg_wr.addr == `TTC_CLR_OFFSET);

    // Per-bit set/clear
    for (genvar b = 0; b < 32; b++) begin : g_bit
        if (((`TTC_IMPL_MASK >> b) & 32'h1) != 32'h0) begin : g_impl
            assign ctl_nxt[b] = (set_hit && reg_wr.wdata[b]) ? 1'b1 :
                                (clr_hit && reg_wr.wdata[b]) ? 1'b0 :
                                ctl_r[b];
        end else begin : g_rsvd
            assign ctl_nxt[b] = 1'b0;
        end
    end

    // Bits kept across ordinary resets
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            global_reset_n_r <= 32'h0;
        end else begin
            global_reset_n_r <= ctl_nxt & `TTC_GLOBAL_RESET_N_MASK;
        end
    end

    // Threshold field on the block reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_r <= 2'h1;
        end else begin
            thresh_r <= ctl_nxt[`TTC_THRESH_HI:`TTC_THRESH_LO];
        end
    end

    // Assembled register
    assign ctl_r = global_reset_n_r | {18'h0, thresh_r, 12'h0};

    // Threshold code
    assign th_sel = ttc_thresh_e'(thresh_r);

    // Store-and-forward override
    assign force_saf = underrun_seen_r ||
                       sf_pkt_r ||
                       fifo.retry ||
                       retry_limit_zero;

    // Selected start level
    always_comb begin
        if (force_saf) begin
            level = `TTC_THRESH_2K;
        end else begin
            unique case (th_sel)
                TTC_TH_STORE: level = `TTC_THRESH_2K;
                TTC_TH_1K7:   level = `TTC_THRESH_1K7;
                TTC_TH_1K:    level = `TTC_THRESH_1K;
                TTC_TH_512:   level = `TTC_THRESH_512;
            endcase
        end
    end

    // Underrun history
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            underrun_seen_r <= 1'b0;
        end else if (fifo.underrun) begin
            underrun_seen_r <= 1'b1;
        end
    end

    // Retried packet flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sf_pkt_r <= 1'b0;
        end else if (fifo.underrun || fifo.retry) begin
            sf_pkt_r <= 1'b1;
        end else if (fifo.pkt_done) begin
            sf_pkt_r <= 1'b0;
        end
    end

    // Packet boundary
    assign pkt_clear = fifo.pkt_done || fifo.underrun;

    // Start decision
    assign cnt_full    = (byte_cnt_r == 12'hfff);
    assign cnt_reached = (level != `TTC_THRESH_2K) && (byte_cnt_r >= level);
    assign start_req   = !started_r && (eop_r || cnt_reached);

    // Byte count of the held packet
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            byte_cnt_r <= 12'h0;
        end else if (pkt_clear) begin
            byte_cnt_r <= 12'h0;
        end else if (fifo.byte_in && !cnt_full) begin
            byte_cnt_r <= byte_cnt_r + 12'h1;
        end
    end

    // Packet end stored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eop_r <= 1'b0;
        end else if (pkt_clear) begin
            eop_r <= 1'b0;
        end else if (fifo.eop_in) begin
            eop_r <= 1'b1;
        end
    end

    // One start per packet
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            started_r <= 1'b0;
        end else if (pkt_clear) begin
            started_r <= 1'b0;
        end else if (start_req) begin
            started_r <= 1'b1;
        end
    end

    // Start pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_start <= 1'b0;
        end else begin
            tx_start <= start_req && !pkt_clear;
        end
    end

    // Format matches
    assign mpeg_hit = ctl_r[`TTC_MPEG_BIT] && (stream_fmt == `TTC_FMT_MPEG);
    assign dv_hit   = ctl_r[`TTC_DV_BIT] && (stream_fmt == `TTC_FMT_DV);

    // Stamp enable
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            stamp_apply <= 1'b0;
        end else begin
            stamp_apply <= mpeg_hit || dv_hit;
        end
    end

    // Priority enable
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            prio_arb_en <= 1'b0;
        end else begin
            prio_arb_en <= ctl_r[`TTC_PRIO_BIT];
        end
    end

    // Acceleration notice
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            accel_notify <= 1'b0;
        end else begin
            accel_notify <= ctl_r[`TTC_ACCEL_BIT];
        end
    end

    // Pipelining disable
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            pipeline_dis <= 1'b0;
        end else begin
            pipeline_dis <= ctl_r[`TTC_DIS_PIPE_BIT];
        end
    end

    // Readback
    always_ff @(posedge mclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= ctl_r & `TTC_IMPL_MASK;
        end
    end

endmodule

/* File: ttc_regs.svh */
// Register offsets, field positions, reset values and thresholds
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH
`define TTC_SET_OFFSET     12'ha88
`define TTC_CLR_OFFSET     12'ha8c
`define TTC_DIS_PIPE_BIT   15
`define TTC_THRESH_HI      13
`define TTC_THRESH_LO      12
`define TTC_MPEG_BIT       10
`define TTC_DV_BIT         8
`define TTC_PRIO_BIT       7
`define TTC_ACCEL_BIT      1
`define TTC_IMPL_MASK      32'h0000b582
`define TTC_GLOBAL_RESET_N_MASK      32'h00008582
`define TTC_RESET_VALUE    32'h00001000
`define TTC_THRESH_2K      12'h800
`define TTC_THRESH_1K7     12'h6cc
`define TTC_THRESH_1K      12'h400
`define TTC_THRESH_512     12'h200
`define TTC_FMT_MPEG       6'h20
`define TTC_FMT_DV         6'h00
`endif

/* File: ttc_pkg.sv */
// Types for the transmit tuning control block
package ttc_pkg;
    typedef enum logic [1:0] {
        TTC_TH_STORE = 2'h0,
        TTC_TH_1K7   = 2'h1,
        TTC_TH_1K    = 2'h2,
        TTC_TH_512   = 2'h3
    } ttc_thresh_e;

    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ttc_wr_s;

    typedef struct packed {
        logic        byte_in;
        logic        eop_in;
        logic        underrun;
        logic        retry;
        logic        pkt_done;
    } ttc_fifo_s;
endpackage

/* File: ttc_props.sv */
// Port checks for the transmit tuning control block
module ttc_props
    import ttc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        global_reset_n,
    input wire ttc_wr_s     reg_wr,
    input wire logic [31:0] reg_rdata,
    input wire ttc_fifo_s   fifo,
    input wire logic        retry_limit_zero,
    input wire logic [5:0]  stream_fmt,
    input wire logic        tx_start,
    input wire logic        stamp_apply,
    input wire logic        prio_arb_en,
    input wire logic        accel_notify,
    input wire logic        pipeline_dis
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n || !global_reset_n);
    chk_rsvd_zero: assert property ((reg_rdata & ~32'h0000b582) == 32'h0)
        else $error("reserved bits nonzero");
    chk_out_mirror: assert property ({prio_arb_en, accel_notify} == {reg_rdata[7], reg_rdata[1]})
        else $error("enable outputs disagree with readback");
    chk_stamp_fmt: assert property (stamp_apply == (reg_rdata[10] && $past(stream_fmt) == 6'h20
        || reg_rdata[8] && $past(stream_fmt) == 6'h00)) else $error("stamp enable wrong");
    chk_set_prio: assert property (reg_wr.wr && reg_wr.addr == 12'ha88 && reg_wr.wdata[7]
        |-> ##[1:2] prio_arb_en) else $error("set did not raise priority enable");
    chk_clr_accel: assert property (reg_wr.wr && reg_wr.addr == 12'ha8c && reg_wr.wdata[1]
        |-> ##[1:2] !accel_notify) else $error("clear did not drop acceleration");
    chk_start_pulse: assert property (tx_start |=> !tx_start) else $error("start too long");
    chk_start_cause: assert property (tx_start |-> $past(fifo.byte_in) || $past(fifo.byte_in, 2)
        || $past(fifo.eop_in, 2) || $past(fifo.eop_in, 3)) else $error("start without cause");
    chk_saf_wait: assert property (tx_start && retry_limit_zero |-> $past(fifo.eop_in)
        || $past(fifo.eop_in, 2) || $past(fifo.eop_in, 3)) else $error("start before packet end");
endmodule
bind ttc_top ttc_props PROPS (.*);

/* File: ttc_phy_model.sv */
// Far-side model counting transmit start requests
module ttc_phy_model (
    input wire logic mclk,
    input wire logic tx_start,
    output int       starts
);
    timeunit 1ns;
    timeprecision 100ps;
    initial starts = 0;
    always @(posedge mclk) if (tx_start === 1'b1) starts <= starts + 1;
endmodule

/* File: async_tx_threshold_ctrl_bench.sv */
// Self-checking bench for the transmit tuning control block
module async_tx_threshold_ctrl_bench;
    import ttc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, rst_n, global_reset_n, retry_limit_zero, tx_start;
    logic        stamp_apply, prio_arb_en, accel_notify, pipeline_dis;
    logic [5:0]  stream_fmt;
    logic [31:0] reg_rdata;
    ttc_wr_s     reg_wr;
    ttc_fifo_s   fifo;
    int          mismatches, checked, cyc, starts, n;
    int          rows [4] = '{0, 1740, 1024, 512};
    ttc_top DUT (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .global_reset_n   (global_reset_n),
        .reg_wr           (reg_wr),
        .reg_rdata        (reg_rdata),
        .fifo             (fifo),
        .retry_limit_zero (retry_limit_zero),
        .stream_fmt       (stream_fmt),
        .tx_start         (tx_start),
        .stamp_apply      (stamp_apply),
        .prio_arb_en      (prio_arb_en),
        .accel_notify     (accel_notify),
        .pipeline_dis     (pipeline_dis)
    );
    ttc_phy_model PHY (.mclk(mclk), .tx_start(tx_start), .starts(starts));
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge mclk) reg_wr <= '{1'b1, a, d};
        @(posedge mclk) reg_wr.wr <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic fp(ttc_fifo_s v);
        @(posedge mclk) fifo <= v;
        @(posedge mclk) fifo <= '0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic pkt(int m, output int got);
        int s0;
        s0 = starts;
        got = 0;
        for (int i = 1; i <= m && got == 0; i++) begin
            @(posedge mclk) fifo.byte_in <= 1'b1;
            if (starts != s0) got = i;
        end
        fp('0);
    endtask
    task automatic saf(int m);
        int s0;
        s0 = starts;
        pkt(m, n);
        chk("early", n, 0);
        fp(5'h08);
        chk("eop_start", starts, s0 + 1);
        fp(5'h01);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        {rst_n, global_reset_n, retry_limit_zero} = '0;
        reg_wr = '0;
        fifo = '0;
        stream_fmt = 6'h20;
        repeat (4) @(posedge mclk);
        {rst_n, global_reset_n} <= 2'b11;
        repeat (3) @(posedge mclk);
        #1 chk("reset", reg_rdata, 32'h1000);
        foreach (rows[i]) begin
            wr(12'ha8c, 32'h3000);
            wr(12'ha88, i << 12);
            chk("thresh", reg_rdata, i << 12);
            if (i == 0) saf(2100);
            else begin
                pkt(2100, n);
                chk("start_at", n >= rows[i] && n <= rows[i] + 4, 1);
                fp(5'h01);
            end
        end
        retry_limit_zero <= 1'b1;
        saf(600);
        retry_limit_zero <= 1'b0;
        fp(5'h04);
        saf(600);
        wr(12'ha88, 32'hffffffff);
        chk("set_all", reg_rdata, 32'h0000b582);
        chk("mpeg", stamp_apply, 1);
        chk("enables", {pipeline_dis, prio_arb_en, accel_notify}, 32'h7);
        stream_fmt <= 6'h05;
        repeat (3) @(posedge mclk);
        #1 chk("other_fmt", stamp_apply, 0);
        @(posedge mclk) rst_n <= 1'b0;
        @(posedge mclk) rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("block_rst", reg_rdata, 32'h00009582);
        fp(5'h02);
        saf(1800);
        @(posedge mclk) global_reset_n <= 1'b0;
        @(posedge mclk) global_reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("global_reset_n", {prio_arb_en, reg_rdata}, 33'h1000);
        wr(12'ha90, 32'hffffffff);
        chk("unmapped", reg_rdata, 32'h1000);
        wr(12'ha8c, 32'hffffffff);
        chk("clear", reg_rdata, 32'h0);
        report_and_stop();
    end
endmodule
